// >>> hw/efs_top.sv
// Purpose: Encoder feedback supervisor: wire break, supply trips, init, auto-configure
// Assumes: Feedback engine signals share clk_sys; pin flags are asynchronous
// Notes:   Trips are sticky, write one to clear; clearing restarts initialisation
//
// What this block does
// - Incremental detector inputs raise wire-break trip
// - Low sine/cosine magnitude raises wire-break trip
// - Comms timeout or checksum raise own trips
// - Serial start/supply bits wrong raise trips
// - Init at power-up, request, trip reset
// - Init re-interrogates comms encoders, auto-configures
// - Servo types use commutation for 120 degrees
// - Per-type settling delay before reading position
// - Supply overloads switch encoder supply off
// - Encoder supply overload detection delayed 40 ms
// - Supply trips override encoder trips
// - Log keeps original trip, then supply trip
// - Interrogate comms encoders at power-up
// - Auto-configure writes ratio, lines, resolution; select for sine/cosine types only
// - Unrecognised, comms error, range raise trips
// - Rotary values taken directly from encoder
// - Linear resolution is position field width
// - Linear ratio is period over LSB length
// - Lines = pitch times pairs over period
// - Lines per rev change only at configure
// - Pitch times pairs clamped to 655.35 mm
// - Zero or above 50000 lines raises trip
// - Mask bits disable three trip detectors
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "efs_consts.svh"
module efs_top #(
  parameter int DLY_SCA_CYC = `EFS_DLY_SCA_MS * `EFS_CLK_KHZ,
  parameter int DLY_SCB_CYC = `EFS_DLY_SCB_MS * `EFS_CLK_KHZ,
  parameter int DLY_OTH_CYC = `EFS_DLY_OTH_MS * `EFS_CLK_KHZ,
  parameter int SUP_DLY_CYC = `EFS_SUP_DLY_MS * `EFS_CLK_KHZ,
  parameter logic [15:0] SC_WB_LEVEL = `EFS_SC_WB_LVL
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // AXI4-Lite slave
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Asynchronous pin flags
  input  wire logic        wb_det_a,
  input  wire logic        wb_det_b,
  input  wire logic        wb_det_z,
  input  wire logic        enc_supply_ovl,
  input  wire logic        int24_ovl,
  // Feedback engine status
  input  wire logic        sc_mag_valid,
  input  wire logic [15:0] sc_mag,
  input  wire logic        comms_timeout,
  input  wire logic        comms_crc_err,
  input  wire logic        comms_enc_err,
  input  wire logic        phase_err,
  input  wire logic        align_fail,
  input  wire logic        ssi_msg_valid,
  input  wire logic        ssi_start_bit,
  input  wire logic        ssi_psu_bit,
  input  wire logic        commut_120_done,
  // Interrogation results
  input  wire logic        id_done,
  input  wire logic        id_error,
  input  wire logic        id_recognised,
  input  wire logic        id_linear,
  input  wire logic [15:0] id_turns,
  input  wire logic [7:0]  id_res,
  input  wire logic [15:0] id_lines,
  input  wire logic [31:0] id_period_nm,
  input  wire logic [31:0] id_lsb_nm,
  // Control outputs
  output logic             supply_en,
  output logic             comms_init_req,
  output logic             commut_sel,
  output logic             init_busy
);
  import efs_pkg::*;

  function automatic logic is_incr(input efs_enc_e t);
    return t inside {quadrature_incremental, freq_direction_incremental, fwd_reverse_incremental,
                     quadrature_with_commutation, freq_dir_with_commutation, fwd_rev_with_commutation};
  endfunction : is_incr

  function automatic logic is_servo(input efs_enc_e t);
    return t inside {quadrature_with_commutation, freq_dir_with_commutation, fwd_rev_with_commutation};
  endfunction : is_servo

  function automatic logic is_sc(input efs_enc_e t);
    return t inside {sine_cosine_plain, sine_cosine_comms_a, sine_cosine_comms_b, sine_cosine_sync_serial};
  endfunction : is_sc

  function automatic logic is_comms(input efs_enc_e t);
    return t inside {sine_cosine_comms_a, sine_cosine_comms_b, abs_comms_b};
  endfunction : is_comms

  function automatic logic [31:0] udiv(input logic [31:0] a, input logic [31:0] b);
    return (b == 32'h0000_0000) ? 32'h0000_0000 : a / b;
  endfunction : udiv

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (s[i])
        r[i*8 +: 8] = d[i*8 +: 8];
    return r;
  endfunction : wmerge

  function automatic logic [3:0] pri_code(input efs_trip_t v);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 10; i >= 0; i--)
      if (v[i])
        c = 4'(i + 1);
    return c;
  endfunction : pri_code

  // Two-stage synchronisers for pin flags
  logic [4:0] pin_m;
  logic [4:0] pin_s;
  always_ff @(posedge clk_sys)
  begin
    pin_m <= {int24_ovl, enc_supply_ovl, wb_det_z, wb_det_b, wb_det_a};
    pin_s <= pin_m;
  end
  wire wb_any_s = |pin_s[2:0];
  wire sup_ovl_s = pin_s[3];
  wire int_ovl_s = pin_s[4];

  // Registers and state
  logic [31:0] ctrl;
  logic [31:0] motor;
  efs_trip_t   trip;
  logic [15:0] turns_ratio;
  logic [15:0] equiv_lines_per_rev;
  logic [7:0]  comms_res;
  logic [1:0]  rotary_select;
  logic [3:0]  log_last;
  logic [3:0]  log_prev;
  logic [27:0] cnt;
  logic [27:0] sup_cnt;
  logic        por_done;
  efs_state_e  st;
  efs_state_e  next_st;

  // Bus decode
  wire wr_fire = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
  wire rd_fire = s_axi_arvalid & s_axi_arready;
  wire wr_ctrl = wr_fire & (s_axi_awaddr == `EFS_A_CTRL);
  wire wr_trip = wr_fire & (s_axi_awaddr == `EFS_A_TRIP);
  wire wr_motor = wr_fire & (s_axi_awaddr == `EFS_A_MOTOR);
  wire wr_ok = wr_ctrl | wr_trip | wr_motor;
  wire rd_hit = s_axi_araddr[7:5] == 3'h0 && s_axi_araddr[1:0] == 2'h0;
  wire reinit_wr = wr_ctrl & s_axi_wstrb[0] & s_axi_wdata[`EFS_B_REINIT];

  // Control fields
  wire       auto_en = ctrl[`EFS_B_AUTO];
  wire [2:0] trip_mask = ctrl[`EFS_B_MASK +: 3];
  wire       psu_mon = ctrl[`EFS_B_PSUMON];
  wire efs_enc_e enc = efs_enc_e'(ctrl[`EFS_B_TYPE +: 4]);
  wire [15:0] pole_pitch = motor[15:0];
  wire [7:0]  pole_pairs = motor[23:16];

  // Settling delay per type
  wire [27:0] dly_cyc = is_incr(enc) ? 28'h000_0000 :
                        (enc == sine_cosine_comms_a) ? 28'(DLY_SCA_CYC) :
                        (enc inside {sine_cosine_comms_b, abs_comms_b}) ? 28'(DLY_SCB_CYC) :
                        28'(DLY_OTH_CYC);

  // Auto-configuration arithmetic
  wire [23:0] pp_raw = pole_pitch * pole_pairs;
  wire [15:0] pp_clamped = (pp_raw > 24'(`EFS_PP_MAX)) ? `EFS_PP_MAX : pp_raw[15:0];
  wire [31:0] equiv_lines_per_rev_lin = udiv(32'(pp_clamped) * `EFS_NM_PER_LSB, id_period_nm);
  wire [31:0] ratio_lin = udiv(id_period_nm, id_lsb_nm);
  wire [31:0] equiv_lines_per_rev_new = id_linear ? equiv_lines_per_rev_lin : 32'(id_lines);
  wire        range_bad = equiv_lines_per_rev_new == 32'h0000_0000 || equiv_lines_per_rev_new > `EFS_EQUIV_LINES_PER_REV_MAX;

  // Trip events
  wire        run = st == st_run;
  wire        supply_off = trip[`EFS_T_SUP] | trip[`EFS_T_INT24];
  wire        enc_ok = run & ~supply_off;
  wire        ssi_chk = enc_ok & psu_mon & ~trip_mask[2] & ssi_msg_valid &
                        (enc inside {sine_cosine_sync_serial, sync_serial_abs});
  wire        sup_evt = sup_ovl_s && sup_cnt == 28'(SUP_DLY_CYC - 1);
  wire        cfg_fail = st == st_config & ~id_recognised;
  efs_trip_t  trip_evt;
  always_comb
  begin
    trip_evt = '0;
    trip_evt[`EFS_T_SUP] = sup_evt;
    trip_evt[`EFS_T_INT24] = int_ovl_s;
    trip_evt[`EFS_T_WB] = enc_ok & ~trip_mask[0] &
                          ((is_incr(enc) & wb_any_s) |
                           (is_sc(enc) & sc_mag_valid & (sc_mag < SC_WB_LEVEL)));
    trip_evt[`EFS_T_TMO] = enc_ok & is_comms(enc) & comms_timeout;
    trip_evt[`EFS_T_CRC] = (enc_ok & is_comms(enc) & comms_crc_err) |
                           (ssi_chk & ~ssi_start_bit);
    trip_evt[`EFS_T_ENCERR] = (enc_ok & is_comms(enc) & comms_enc_err) | (ssi_chk & ssi_psu_bit);
    trip_evt[`EFS_T_PHASE] = enc_ok & ~trip_mask[1] & phase_err;
    trip_evt[`EFS_T_ALIGN] = ~supply_off & is_sc(enc) & align_fail & (st != st_idle);
    trip_evt[`EFS_T_INIT] = st == st_interrogate & id_done & id_error;
    trip_evt[`EFS_T_TYPE] = cfg_fail;
    trip_evt[`EFS_T_PERIOD] = st == st_config & id_recognised & range_bad;
  end

  wire        supply_rise = (trip_evt[`EFS_T_SUP] & ~trip[`EFS_T_SUP]) |
                            (trip_evt[`EFS_T_INT24] & ~trip[`EFS_T_INT24]);
  wire efs_trip_t clr_mask = wr_trip ? {s_axi_wstrb[1] ? s_axi_wdata[10:8] : 3'h0,
                                         s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00} : '0;
  wire efs_trip_t ovr_mask = supply_rise ? `EFS_OVR_MASK : '0;
  // Set wins over clear and over override
  wire efs_trip_t next_trip = (trip & ~clr_mask & ~ovr_mask) | trip_evt;
  wire efs_trip_t new_bits = trip_evt & ~trip;
  wire        init_start = ~por_done | reinit_wr | (|(clr_mask & trip));

  // Initialisation sequencer
  always_comb
  begin
    next_st = st;
    case (st)
      st_idle:        next_st = st_idle;
      st_power_wait:  if (cnt >= dly_cyc)
                        next_st = is_comms(enc) ? st_interrogate : st_run;
      st_interrogate: if (id_done)
                        next_st = id_error ? st_idle : (auto_en ? st_config : st_run);
      st_config:      next_st = (cfg_fail | range_bad) ? st_idle : st_run;
      st_run:         next_st = st_run;
      default:        next_st = st_idle;
    endcase
    if (init_start)
      next_st = st_power_wait;
  end
  wire enter_run = next_st == st_run && st != st_run;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st <= st_idle;
      cnt <= 28'h000_0000;
      por_done <= 1'b0;
    end
    else
    begin
      st <= next_st;
      por_done <= 1'b1;
      // Count only while the encoder is powered
      cnt <= (next_st != st_power_wait || init_start) ? 28'h000_0000 :
             (supply_off ? cnt : cnt + 28'h000_0001);
    end
  end

  // Encoder supply overload qualification
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      sup_cnt <= 28'h000_0000;
    else
      sup_cnt <= (sup_ovl_s && sup_cnt != 28'(SUP_DLY_CYC - 1)) ? sup_cnt + 28'h000_0001 :
                 28'h000_0000;
  end

  // Trips, log and auto-configured values
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      trip <= '0;
      log_last <= 4'h0;
      log_prev <= 4'h0;
      turns_ratio <= 16'h0000;
      equiv_lines_per_rev <= 16'h0000;
      comms_res <= 8'h00;
      rotary_select <= 2'h0;
    end
    else
    begin
      trip <= next_trip;
      if (|new_bits)
      begin
        log_prev <= log_last;
        log_last <= pri_code(new_bits);
      end
      if (st == st_config && id_recognised && !range_bad)
      begin
        turns_ratio <= id_linear ? ratio_lin[15:0] : id_turns;
        equiv_lines_per_rev <= equiv_lines_per_rev_new[15:0];
        comms_res <= id_res;
        if (is_sc(enc))
          rotary_select <= id_linear ? 2'h0 : 2'h1;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      supply_en <= 1'b0;
      comms_init_req <= 1'b0;
      commut_sel <= 1'b0;
      init_busy <= 1'b0;
    end
    else
    begin
      supply_en <= ~(next_trip[`EFS_T_SUP] | next_trip[`EFS_T_INT24]);
      comms_init_req <= next_st == st_interrogate && st != st_interrogate;
      commut_sel <= (enter_run & is_servo(enc)) |
                    (commut_sel & ~commut_120_done & next_st == st_run);
      init_busy <= next_st != st_run && next_st != st_idle;
    end
  end

  // Software registers
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ctrl <= `EFS_CTRL_RST;
      motor <= `EFS_MOTOR_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= wmerge(ctrl, s_axi_wdata, s_axi_wstrb) & ~(32'h1 << `EFS_B_REINIT);
      if (wr_motor)
        motor <= wmerge(motor, s_axi_wdata, s_axi_wstrb);
    end
  end

  // Read selection
  wire [31:0] stat_word = {24'h00_0000, 1'b0, commut_sel, supply_en, init_busy, 1'b0, 3'(st)};
  wire [31:0] rd_word = (s_axi_araddr == `EFS_A_CTRL)  ? ctrl :
                        (s_axi_araddr == `EFS_A_TRIP)  ? 32'(trip) :
                        (s_axi_araddr == `EFS_A_MOTOR) ? motor :
                        (s_axi_araddr == `EFS_A_STAT)  ? stat_word :
                        (s_axi_araddr == `EFS_A_RATIO) ? 32'(turns_ratio) :
                        (s_axi_araddr == `EFS_A_EQUIV_LINES_PER_REV)  ? 32'(equiv_lines_per_rev) :
                        (s_axi_araddr == `EFS_A_RES)   ? {22'h00_0000, rotary_select, comms_res} :
                        {24'h00_0000, log_prev, log_last};

  // AXI4-Lite handshakes
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EFS_RESP_OK;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `EFS_RESP_OK;
    end
    else
    begin
      // Address and data taken together keeps one write in flight
      s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `EFS_RESP_OK : `EFS_RESP_ERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_hit ? rd_word : 32'h0000_0000;
        s_axi_rresp <= rd_hit ? `EFS_RESP_OK : `EFS_RESP_ERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_supply_off: assert property (supply_off |-> !supply_en)
    else $error("supply on during supply trip");
  a_sup_delay: assert property ($rose(trip[`EFS_T_SUP]) |-> $past(sup_ovl_s) &&
    $past(sup_cnt) == 28'(SUP_DLY_CYC - 1))
    else $error("supply trip without full delay");
  a_override_enc: assert property (supply_rise && !(|(trip_evt & `EFS_OVR_MASK))
    |=> (trip & `EFS_OVR_MASK) == '0)
    else $error("encoder trip survived supply trip");
  a_log_supply: assert property ($rose(trip[`EFS_T_SUP]) |-> log_last == 4'h1)
    else $error("supply trip not logged last");
  a_wire_break: assert property (enc_ok && !trip_mask[0] && is_incr(enc) && wb_any_s
    |=> trip[`EFS_T_WB])
    else $error("incremental wire break missed");
  a_sc_level: assert property (enc_ok && !trip_mask[0] && is_sc(enc) && sc_mag_valid &&
    sc_mag < SC_WB_LEVEL |=> trip[`EFS_T_WB])
    else $error("sine cosine wire break missed");
  a_comms_tmo: assert property (enc_ok && is_comms(enc) && comms_timeout
    |=> trip[`EFS_T_TMO])
    else $error("comms timeout missed");
  a_ssi_bits: assert property (ssi_chk && ssi_psu_bit |=> trip[`EFS_T_ENCERR])
    else $error("serial supply bit missed");
  a_init_start: assert property (reinit_wr |=> st == st_power_wait && cnt == 28'h000_0000)
    else $error("reinit did not restart");
  a_wait_delay: assert property (st == st_power_wait && cnt < dly_cyc && !init_start
    |=> st == st_power_wait)
    else $error("left settling wait early");
  a_equiv_lines_per_rev_hold: assert property (st != st_config |=> $stable(equiv_lines_per_rev))
    else $error("lines per rev changed outside configure");
  a_period_trip: assert property (st == st_config && id_recognised && range_bad
    |=> trip[`EFS_T_PERIOD] && st != st_run)
    else $error("period range trip missed");
  a_trip_latch: assert property (trip[`EFS_T_WB] && !clr_mask[`EFS_T_WB] && !supply_rise
    |=> trip[`EFS_T_WB])
    else $error("wire break trip dropped");
  c_comms_init: cover property (st == st_config ##1 st == st_run);
  c_override: cover property (trip[`EFS_T_WB] ##1 trip[`EFS_T_SUP] && !trip[`EFS_T_WB]);
  c_servo_run: cover property ($rose(commut_sel) ##[1:50] $fell(commut_sel));
endmodule : efs_top

// >>> hw/efs_consts.svh
// Purpose: Constants for the encoder feedback supervisor
// Assumes: 125 MHz system clock
// Notes:   Offsets are AXI4-Lite byte addresses
`ifndef EFS_CONSTS_SVH
`define EFS_CONSTS_SVH
`define EFS_CLK_KHZ     125000
`define EFS_DLY_SCA_MS  150
`define EFS_DLY_SCB_MS  1000
`define EFS_DLY_OTH_MS  1200
`define EFS_SUP_DLY_MS  40
`define EFS_EQUIV_LINES_PER_REV_MAX    32'h0000_c350
`define EFS_PP_MAX      16'hffff
`define EFS_NM_PER_LSB  32'h0000_2710
`define EFS_SC_WB_LVL   16'h0400
`define EFS_A_CTRL      8'h00
`define EFS_A_TRIP      8'h04
`define EFS_A_MOTOR     8'h08
`define EFS_A_STAT      8'h0c
`define EFS_A_RATIO     8'h10
`define EFS_A_EQUIV_LINES_PER_REV      8'h14
`define EFS_A_RES       8'h18
`define EFS_A_LOG       8'h1c
`define EFS_B_AUTO      0
`define EFS_B_REINIT    1
`define EFS_B_MASK      4
`define EFS_B_PSUMON    7
`define EFS_B_TYPE      8
`define EFS_CTRL_RST    32'h0000_0000
`define EFS_MOTOR_RST   32'h0000_0000
`define EFS_T_SUP       0
`define EFS_T_WB        1
`define EFS_T_TMO       2
`define EFS_T_CRC       3
`define EFS_T_ENCERR    4
`define EFS_T_INIT      5
`define EFS_T_ALIGN     6
`define EFS_T_TYPE      7
`define EFS_T_PERIOD    8
`define EFS_T_INT24     9
`define EFS_T_PHASE     10
`define EFS_OVR_MASK    11'h47e
`define EFS_RESP_OK     2'h0
`define EFS_RESP_ERR    2'h2
`endif

// >>> hw/efs_pkg.sv
// Purpose: Types for the encoder feedback supervisor
// Assumes: Nothing beyond the consts header
// Notes:   Encoder codes follow the type field of the control word
package efs_pkg;
  typedef enum logic [3:0] {
    quadrature_incremental, freq_direction_incremental, fwd_reverse_incremental,
    quadrature_with_commutation, freq_dir_with_commutation, fwd_rev_with_commutation,
    sine_cosine_plain, sine_cosine_comms_a, sine_cosine_comms_b, abs_comms_b,
    sine_cosine_sync_serial, sync_serial_abs
  } efs_enc_e;
  typedef enum {st_idle, st_power_wait, st_interrogate, st_config, st_run} efs_state_e;
  typedef logic [10:0] efs_trip_t;
endpackage : efs_pkg

// >>> sim/efs_enc_model.sv
// Purpose: Encoder-side model: interrogation answers, serial status bits
// Assumes: Fixed answer latency after each init request
// Notes:   Stale id fields invert so a late read shows up
`timescale 1ns/1ps
module efs_enc_model (
  input  wire logic        clk_sys, rst_n, comms_init_req, cfg_lin, cfg_bad_psu,
  input  wire logic [31:0] cfg_per,
  input  wire logic [15:0] cfg_lines,
  output logic             id_done, id_linear, ssi_msg_valid, ssi_start_bit, ssi_psu_bit,
  output wire logic        id_error, id_recognised,
  output logic [15:0]      id_turns, id_lines,
  output logic [7:0]       id_res,
  output logic [31:0]      id_period_nm, id_lsb_nm
);
  logic [3:0] cnt;
  logic       hold;
  assign id_error = 1'b0;
  assign id_recognised = 1'b1;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      {cnt, hold, id_done, ssi_msg_valid} <= '0;
      {id_linear, id_turns, id_lines, id_res, id_period_nm, id_lsb_nm} <= '0;
    end
    else
    begin
      cnt <= comms_init_req ? 4'h5 : (cnt != 4'h0 ? cnt - 4'h1 : cnt);
      id_done <= (cnt == 4'h1);
      hold <= id_done;
      ssi_msg_valid <= !ssi_msg_valid;
      // Bits outside a message are inverted from their in-message values
      ssi_start_bit <= !ssi_msg_valid;
      ssi_psu_bit <= ssi_msg_valid ^ cfg_bad_psu;
      if (cnt == 4'h1)
        {id_linear, id_turns, id_lines, id_res, id_period_nm, id_lsb_nm} <=
          {cfg_lin, 16'h0010, cfg_lines, 8'h14, cfg_per, 32'h0000_0032};
      else if (hold)
        {id_linear, id_lines, id_period_nm} <= ~{id_linear, id_lines, id_period_nm};
    end
  end
endmodule : efs_enc_model

// >>> sim/encoder_feedback_supervisor_bench.sv
// Purpose: Self-checking bench for the encoder feedback supervisor
// Assumes: Shortened settling and overload counts
// Notes:   Comms types add the model's answer latency to init time
`timescale 1ns/1ps
`include "efs_consts.svh"
module encoder_feedback_supervisor_bench;
  import efs_pkg::*;
  localparam int DA = 20, DB = 30, DO = 40, DS = 10;
  logic clk_sys = 1'b0, rst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cfg_lin = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, np;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = '0, cfg_per = '0, rd, e, seed = 32'h3cfb_d309;
  logic [15:0] sc_mag = '0, cfg_lines = '0, pp;
  logic [1:0] rsp, bsp;
  logic [12:0] ev = '0;
  int error_cnt = 0, samples_checked = 0, n;
  int ty[8] = '{0, 3, 6, 7, 8, 9, 10, 12};
  int dl[8] = '{0, 0, DO, DA, DB, DB, DO, DO};
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, supply_en, comms_init_req;
  wire commut_sel, init_busy, id_done, id_error, id_recognised, id_linear, ssi_msg_valid, ssi_start_bit, ssi_psu_bit;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, id_period_nm, id_lsb_nm;
  wire [15:0] id_turns, id_lines;
  wire [7:0] id_res;
  wire wb_det_a, wb_det_b, wb_det_z, comms_timeout, comms_crc_err, comms_enc_err, phase_err, align_fail;
  wire commut_120_done, sc_mag_valid, enc_supply_ovl, int24_ovl, cfg_bad_psu;
  assign {cfg_bad_psu, int24_ovl, enc_supply_ovl, sc_mag_valid, commut_120_done, align_fail, phase_err,
          comms_enc_err, comms_crc_err, comms_timeout, wb_det_z, wb_det_b, wb_det_a} = ev;
  efs_top #(.DLY_SCA_CYC(DA), .DLY_SCB_CYC(DB), .DLY_OTH_CYC(DO), .SUP_DLY_CYC(DS)) i_dut (.*);
  efs_enc_model i_enc (.*);
  initial forever #4 clk_sys = ~clk_sys;
  task automatic tally_and_finish;
    $display("errors=%0d checks=%0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    do @(posedge clk_sys); while ((s_axi_awready & s_axi_wready) !== 1'b1);
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    while (s_axi_bvalid !== 1'b1) @(posedge clk_sys);
    bsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge clk_sys);
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    s_axi_araddr <= a;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk_sys);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdr
  task automatic idle;
    repeat (2) @(posedge clk_sys);
    n = 0;
    while (init_busy !== 1'b0 && n < 5000)
    begin
      @(posedge clk_sys);
      n++;
    end
  endtask : idle
  task automatic go(input logic [31:0] c);
    wr(`EFS_A_CTRL, c | 32'h0000_0002);
    idle();
  endtask : go
  task automatic hit(input int k, input int len);
    @(posedge clk_sys);
    ev[k] <= 1'b1;
    repeat (len) @(posedge clk_sys);
    ev[k] <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask : hit
  // Raise one event, expect its trip to stay latched, then clear and re-init
  task automatic trip(input int k, input int b);
    hit(k, 2);
    repeat (20) @(posedge clk_sys);
    rdr(`EFS_A_TRIP);
    chk({31'h0, rd[b]}, 32'h1);
    wr(`EFS_A_TRIP, 32'h1 << b);
    idle();
    rdr(`EFS_A_TRIP);
    chk(rd, 32'h0);
  endtask : trip
  function automatic logic [31:0] equiv_lines_per_rev(input logic [15:0] p, input logic [7:0] q, input logic [31:0] per);
    logic [31:0] m;
    m = p * q;
    if (m > 32'h0000_ffff) m = 32'h0000_ffff;
    return (m * 32'h0000_2710) / per;
  endfunction : equiv_lines_per_rev
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    error_cnt++;
    tally_and_finish();
  end
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdr(`EFS_A_CTRL);
    chk(rd, `EFS_CTRL_RST);
    rdr(8'h20);
    chk({30'h0, rsp}, {30'h0, `EFS_RESP_ERR});
    wr(8'h24, 32'h0000_0001);
    chk({30'h0, bsp}, {30'h0, `EFS_RESP_ERR});
    wr(`EFS_A_MOTOR, 32'h0000_0000);
    chk({30'h0, bsp}, {30'h0, `EFS_RESP_OK});
    idle();
    for (int k = 0; k < 3; k++) trip(k, `EFS_T_WB);
    foreach (ty[i])
    begin
      go(32'(ty[i]) << 8);
      chk({31'h0, n >= dl[i] - 2 && n <= dl[i] + 14}, 32'h1);
    end
    go(32'h0000_0300);
    chk({31'h0, commut_sel}, 32'h1);
    hit(8, 2);
    chk({31'h0, commut_sel}, 32'h0);
    go(32'h0000_0700);
    trip(3, `EFS_T_TMO);
    trip(4, `EFS_T_CRC);
    go(32'h0000_0600);
    sc_mag <= `EFS_SC_WB_LVL + 16'($random(seed) & 32'h0fff);
    hit(9, 1);
    rdr(`EFS_A_TRIP);
    chk(rd, 32'h0);
    sc_mag <= `EFS_SC_WB_LVL - 16'h0001;
    trip(9, `EFS_T_WB);
    go(32'h0000_0a80);
    trip(12, `EFS_T_ENCERR);
    for (int i = 0; i < 6; i++)
    begin
      pp = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($random(seed));
      np = (i == 1) ? 8'hff : 8'($random(seed) & 32'h7) + 8'h01;
      cfg_per <= ($random(seed) & 32'h000f_ffff) + 32'h0000_0100;
      cfg_lines <= 16'($random(seed) & 32'h7fff) + 16'h0002;
      cfg_lin <= (i != 5);
      wr(`EFS_A_MOTOR, {8'h00, np, pp});
      wr(`EFS_A_TRIP, 32'h0000_07ff);
      idle();
      go(32'h0000_0801);
      e = cfg_lin ? equiv_lines_per_rev(pp, np, cfg_per) : {16'h0, cfg_lines};
      rdr(`EFS_A_TRIP);
      chk({31'h0, rd[`EFS_T_PERIOD]}, {31'h0, e == 0 || e > 50000});
      if (e != 0 && e <= 50000)
      begin
        rdr(`EFS_A_EQUIV_LINES_PER_REV);
        chk(rd & 32'hffff, e);
        wr(`EFS_A_MOTOR, {8'h00, np + 8'h01, ~pp});
        rdr(`EFS_A_EQUIV_LINES_PER_REV);
        chk(rd & 32'hffff, e);
      end
    end
    go(32'h0);
    hit(0, 2);
    hit(11, 4);
    rdr(`EFS_A_TRIP);
    chk(rd, 32'h0000_0200);
    chk({31'h0, supply_en}, 32'h0);
    rdr(`EFS_A_LOG);
    chk(rd & 32'hff, 32'h0000_002a);
    wr(`EFS_A_TRIP, 32'h0000_0200);
    idle();
    hit(10, DS - 4);
    rdr(`EFS_A_TRIP);
    chk(rd, 32'h0);
    hit(10, DS + 6);
    rdr(`EFS_A_TRIP);
    chk(rd, 32'h1);
    tally_and_finish();
  end
endmodule : encoder_feedback_supervisor_bench
